// ==== hw/tob_defines.vh ====
// Constants for the 16-bit overflow timer and capture/compare time base
`ifndef TOB_DEFINES_VH
`define TOB_DEFINES_VH
// Word addresses (byte address / 4)
`define TOB_ADDR_CONTROL 4'h0
`define TOB_ADDR_CNT_LOW 4'h1
`define TOB_ADDR_CNT_HIGH 4'h2
`define TOB_ADDR_IRQ_ENABLE 4'h3
`define TOB_ADDR_IRQ_REQUEST 4'h4
`define TOB_ADDR_IRQ_CONTROL 4'h5
`define TOB_ADDR_OSC_ENABLE 4'h6
`define TOB_ADDR_MAP_ZERO 4'h7
`define TOB_ADDR_MAP_ONE 4'h8
`define TOB_ADDR_CCP_BASE 4'h9
// Control register fields
`define TOB_CTL_ON 0
`define TOB_CTL_ASYNC 2
`define TOB_CTL_EXTCLK 3
`define TOB_CTL_ATRIG 4
// Capture/compare unit register fields: mode [1:0], low [15:8], high [23:16]
`define TOB_CCP_MODE_OFF 2'h0
`define TOB_CCP_MODE_CAPTURE 2'h1
`define TOB_CCP_MODE_COMPARE 2'h2
`define TOB_CCP_MODE_TRIGGER 2'h3
`define TOB_CCP_VAL_LSB 8
`define TOB_CCP_VAL_MSB 23
`define TOB_IRQ_GLOBAL 7
`define TOB_IRQ_PERIPH 6
`define TOB_WRAP_VALUE 16'hFFFF
`define TOB_ZERO_VALUE 16'h0000
`define TOB_NUM_UNITS 5
`endif

// ==== hw/tob_timer.v ====
// Overflow timer with capture/compare time base and Avalon-MM register slave
`timescale 1ns/1ps
`include "tob_defines.vh"
module tob_timer #(
  parameter UNITS = `TOB_NUM_UNITS
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire SRST,
  // Avalon-MM slave
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // External count clock and capture events, asynchronous
  input wire EXT_COUNT_CLK,
  input wire [UNITS-1:0] CAPTURE_EVENT,
  // Sleep status from the core
  input wire SLEEP_ACTIVE,
  // Outputs
  output reg IRQ_OUT,
  output reg WAKE_OUT,
  output reg OSC_RUN,
  output reg [UNITS-1:0] COMPARE_EVENT,
  output reg [UNITS-1:0] CONVERSION_TRIGGER
);
  reg [7:0] control;
  reg [15:0] cnt [0:2];
  reg overflow_flag;
  reg overflow_irq_enable;
  reg [7:0] irq_control;
  reg low_freq_osc_enable;
  reg [7:0] map_zero;
  reg [7:0] map_one;
  reg [1:0] ccp_mode [0:UNITS-1];
  reg [15:0] ccp_val [0:UNITS-1];
  reg ext_s1, ext_s2, ext_s3;
  reg [UNITS-1:0] cap_s1, cap_s2, cap_s3;
  reg [15:0] next_cnt;
  reg [UNITS-1:0] trig_clear;
  reg wrap;
  reg count_en;
  wire access;
  wire rd_take;
  wire wr_commit;
  wire wr_cnt_low;
  wire wr_cnt_high;
  wire wr_flag;
  // Separate loop indices, so no two processes share a variable
  integer i;
  integer j;
  integer k;

  // Selected timer of a unit, two bits per unit across two map registers
  function [1:0] unit_sel;
    input [7:0] m0;
    input [7:0] m1;
    input integer u;
    reg [15:0] both;
    begin
      both = {m1, m0};
      unit_sel = both[2*u +: 2];
      if (unit_sel == 2'h3) begin
        unit_sel = 2'h0;
      end
    end
  endfunction

  // A request is taken while waitrequest is high; read data is loaded then
  assign access = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
  assign rd_take = AVS_READ & AVS_WAITREQUEST;
  // A write lands only at the edge that completes the transfer
  assign wr_commit = AVS_WRITE & ~AVS_WAITREQUEST;
  assign wr_cnt_low = wr_commit && (AVS_ADDRESS == `TOB_ADDR_CNT_LOW);
  assign wr_cnt_high = wr_commit && (AVS_ADDRESS == `TOB_ADDR_CNT_HIGH);
  assign wr_flag = wr_commit && (AVS_ADDRESS == `TOB_ADDR_IRQ_REQUEST);

  // Count enable: system clock, or external edge with EXTCLK; in sleep only the external edge with ASYNC set
  always @* begin
    if (control[`TOB_CTL_EXTCLK]) begin
      count_en = ext_s2 & ~ext_s3;
    end else begin
      count_en = 1'b1;
    end
    if (SLEEP_ACTIVE && !(control[`TOB_CTL_ASYNC] && control[`TOB_CTL_EXTCLK])) begin
      count_en = 1'b0;
    end
    count_en = count_en & control[`TOB_CTL_ON];
    wrap = count_en && (cnt[0] == `TOB_WRAP_VALUE);
    next_cnt = cnt[0] + 16'h0001;
  end

  // Conversion trigger matches clear timer 0 when it is their base
  always @* begin
    for (k = 0; k < UNITS; k = k + 1) begin
      trig_clear[k] = (ccp_mode[k] == `TOB_CCP_MODE_TRIGGER) && (unit_sel(map_zero, map_one, k) == 2'h0)
        && (ccp_val[k] == cnt[0]) && control[`TOB_CTL_ATRIG];
    end
  end

  // Pin synchronisers; the third stage only serves edge detection
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      cap_s1 <= {UNITS{1'b0}};
      cap_s2 <= {UNITS{1'b0}};
      cap_s3 <= {UNITS{1'b0}};
    end else begin
      ext_s1 <= EXT_COUNT_CLK;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      cap_s1 <= CAPTURE_EVENT;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      control <= 8'h00;
      cnt[0] <= 16'h0000;
      cnt[1] <= 16'h0000;
      cnt[2] <= 16'h0000;
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      irq_control <= 8'h00;
      low_freq_osc_enable <= 1'b0;
      map_zero <= 8'h00;
      map_one <= 8'h00;
      IRQ_OUT <= 1'b0;
      WAKE_OUT <= 1'b0;
      OSC_RUN <= 1'b0;
      COMPARE_EVENT <= {UNITS{1'b0}};
      CONVERSION_TRIGGER <= {UNITS{1'b0}};
      for (i = 0; i < UNITS; i = i + 1) begin
        ccp_mode[i] <= `TOB_CCP_MODE_OFF;
        ccp_val[i] <= 16'h0000;
      end
    end else begin
      // Timers 1 and 2 free-run on the system clock when timer is on and the core is awake
      if (control[`TOB_CTL_ON] && !SLEEP_ACTIVE) begin
        cnt[1] <= cnt[1] + 16'h0001;
        cnt[2] <= cnt[2] + 16'h0001;
      end
      // Main timer: byte write beats trigger clear beats count
      if (wr_cnt_low) begin
        cnt[0][7:0] <= AVS_WRITEDATA[7:0];
      end else if (wr_cnt_high) begin
        cnt[0][15:8] <= AVS_WRITEDATA[7:0];
      end else if (|trig_clear) begin
        cnt[0] <= `TOB_ZERO_VALUE;
      end else if (count_en) begin
        cnt[0] <= next_cnt;
      end
      // Overflow flag: set beats software clear, trigger clear never sets it
      if (wrap && !(|trig_clear)) begin
        overflow_flag <= 1'b1;
      end else if (wr_flag) begin
        overflow_flag <= AVS_WRITEDATA[0];
      end
      IRQ_OUT <= overflow_flag && control[`TOB_CTL_ON] && overflow_irq_enable
        && irq_control[`TOB_IRQ_PERIPH] && irq_control[`TOB_IRQ_GLOBAL] && !SLEEP_ACTIVE;
      WAKE_OUT <= SLEEP_ACTIVE && overflow_flag && control[`TOB_CTL_ON] && overflow_irq_enable
        && irq_control[`TOB_IRQ_PERIPH];
      OSC_RUN <= low_freq_osc_enable;
      for (i = 0; i < UNITS; i = i + 1) begin
        COMPARE_EVENT[i] <= (ccp_mode[i] >= `TOB_CCP_MODE_COMPARE)
          && (ccp_val[i] == cnt[unit_sel(map_zero, map_one, i)]);
        CONVERSION_TRIGGER[i] <= trig_clear[i];
        if (wr_commit && AVS_ADDRESS == `TOB_ADDR_CCP_BASE + i[3:0]) begin
          ccp_mode[i] <= AVS_WRITEDATA[1:0];
          ccp_val[i] <= AVS_WRITEDATA[`TOB_CCP_VAL_MSB:`TOB_CCP_VAL_LSB];
        end else if (ccp_mode[i] == `TOB_CCP_MODE_CAPTURE && cap_s2[i] && !cap_s3[i]) begin
          ccp_val[i] <= cnt[unit_sel(map_zero, map_one, i)];
        end
      end
      // Configuration writes
      if (wr_commit) begin
        case (AVS_ADDRESS)
          `TOB_ADDR_CONTROL: control <= AVS_WRITEDATA[7:0];
          `TOB_ADDR_IRQ_ENABLE: overflow_irq_enable <= AVS_WRITEDATA[0];
          `TOB_ADDR_IRQ_CONTROL: irq_control <= AVS_WRITEDATA[7:0];
          `TOB_ADDR_OSC_ENABLE: low_freq_osc_enable <= AVS_WRITEDATA[0];
          `TOB_ADDR_MAP_ZERO: map_zero <= AVS_WRITEDATA[7:0];
          `TOB_ADDR_MAP_ONE: map_one <= AVS_WRITEDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  // Register slave: one wait cycle, then answer with registered read data
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      AVS_READDATA <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~access;
      if (rd_take) begin
        case (AVS_ADDRESS)
          `TOB_ADDR_CONTROL: AVS_READDATA <= {24'h000000, control};
          `TOB_ADDR_CNT_LOW: AVS_READDATA <= {24'h000000, cnt[0][7:0]};
          `TOB_ADDR_CNT_HIGH: AVS_READDATA <= {24'h000000, cnt[0][15:8]};
          `TOB_ADDR_IRQ_ENABLE: AVS_READDATA <= {31'h00000000, overflow_irq_enable};
          `TOB_ADDR_IRQ_REQUEST: AVS_READDATA <= {31'h00000000, overflow_flag};
          `TOB_ADDR_IRQ_CONTROL: AVS_READDATA <= {24'h000000, irq_control};
          `TOB_ADDR_OSC_ENABLE: AVS_READDATA <= {31'h00000000, low_freq_osc_enable};
          `TOB_ADDR_MAP_ZERO: AVS_READDATA <= {24'h000000, map_zero};
          `TOB_ADDR_MAP_ONE: AVS_READDATA <= {24'h000000, map_one};
          default: begin
            AVS_READDATA <= 32'h00000000;
            for (j = 0; j < UNITS; j = j + 1) begin
              if (AVS_ADDRESS == `TOB_ADDR_CCP_BASE + j[3:0]) begin
                AVS_READDATA <= {8'h00, ccp_val[j], 6'h00, ccp_mode[j]};
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the overflow timer
`timescale 1ns/1ps
module tb_top;
  reg SYS_CLK, SRST, AVS_READ, AVS_WRITE, SLEEP_ACTIVE;
  reg [3:0] AVS_ADDRESS;
  reg [31:0] AVS_WRITEDATA, q;
  reg [15:0] v;
  wire [31:0] AVS_READDATA;
  wire AVS_WAITREQUEST, EXT_COUNT_CLK, IRQ_OUT, WAKE_OUT, OSC_RUN;
  wire [4:0] CAPTURE_EVENT, COMPARE_EVENT, CONVERSION_TRIGGER;
  integer fails, cmp_count, seed, i;
  tob_timer dut(.SYS_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
    .AVS_WAITREQUEST, .EXT_COUNT_CLK, .CAPTURE_EVENT, .SLEEP_ACTIVE, .IRQ_OUT, .WAKE_OUT, .OSC_RUN,
    .COMPARE_EVENT, .CONVERSION_TRIGGER);
  tob_far far(.SYS_CLK, .EXT_COUNT_CLK, .CAPTURE_EVENT);
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task av(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= ~w;
      @(posedge SYS_CLK);
      while (AVS_WAITREQUEST !== 1'b0 && n < 50) begin
        @(posedge SYS_CLK);
        n = n + 1;
      end
      if (n == 50) fails = fails + 1;
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
    end
  endtask
  // Count expected after n increments, rolling over past all ones
  function [15:0] exp_count(input [15:0] s, input integer n);
    exp_count = s + n[15:0];
  endfunction
  task setc(input [15:0] c);
    begin
      av(1, 4'h1, c[7:0]);
      av(1, 4'h2, c[15:8]);
    end
  endtask
  initial begin
    #(25 * 20000);
    fails = fails + 1;
    test_done;
  end
  initial begin
    fails = 0;
    cmp_count = 0;
    seed = 46583;
    SRST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_WRITEDATA = 32'h0;
    SLEEP_ACTIVE = 1'b0;
    repeat (6) @(posedge SYS_CLK);
    SRST <= 1'b0;
    av(0, 4'hF, 0);
    chk("unmap", 0, q);
    setc(16'hFFFE);
    av(0, 4'h1, 0);
    chk("low", 32'hFE, q & 32'hFF);
    av(1, 4'h0, 1);
    av(1, 4'h0, 0);
    av(0, 4'h2, 0);
    chk("wrap", exp_count(16'hFFFE, 3) >> 8, q & 32'hFF);
    av(0, 4'h1, 0);
    chk("wraplow", exp_count(16'hFFFE, 3) & 16'h00FF, q & 32'hFF);
    av(0, 4'h4, 0);
    chk("flag", 1, q & 32'h1);
    av(1, 4'h3, 1);
    for (i = 0; i < 8; i = i + 1) begin
      av(1, 4'h0, i & 1);
      av(1, 4'h5, (i & 6) << 5);
      repeat (3) @(posedge SYS_CLK);
      chk("irq", i == 7, IRQ_OUT);
    end
    SLEEP_ACTIVE <= 1'b1;
    av(1, 4'h6, 1);
    repeat (3) @(posedge SYS_CLK);
    chk("sleepirq", 0, IRQ_OUT);
    chk("osc", 1, OSC_RUN);
    av(1, 4'h4, 0);
    av(1, 4'h0, 0);
    setc(16'hFFFC);
    av(1, 4'h0, 1);
    repeat (20) @(posedge SYS_CLK);
    av(0, 4'h1, 0);
    chk("frozen", 32'hFC, q & 32'hFF);
    chk("noflag", 0, WAKE_OUT);
    av(1, 4'h0, 32'h0D);
    far.ext(5);
    repeat (6) @(posedge SYS_CLK);
    chk("wake", 1, WAKE_OUT);
    av(1, 4'h0, 0);
    av(0, 4'h1, 0);
    chk("extcount", exp_count(16'hFFFC, 5) & 16'h00FF, q & 32'hFF);
    SLEEP_ACTIVE <= 1'b0;
    av(1, 4'h4, 0);
    av(1, 4'h7, 32'hFF);
    av(1, 4'h8, 32'hFF);
    for (i = 0; i < 5; i = i + 1) begin
      v = $random(seed);
      setc(v);
      av(1, 4'h9 + i[3:0], 1);
      far.cap(i);
      repeat (4) @(posedge SYS_CLK);
      av(0, 4'h9 + i[3:0], 0);
      chk("capture", v, q[23:8]);
    end
    // Unit 1 on the first free-running timer must not see the main count
    av(1, 4'h7, 32'h04);
    setc(16'hA5C3);
    far.cap(1);
    repeat (4) @(posedge SYS_CLK);
    av(0, 4'hA, 0);
    cmp_count = cmp_count + 1;
    if (q[23:8] === 16'hA5C3) begin
      fails = fails + 1;
      $display("CHECK FAILED map1 exp other than a5c3 got %h", q[23:8]);
    end
    setc(v);
    av(1, 4'h9, {v, 8'h02});
    repeat (3) @(posedge SYS_CLK);
    chk("compare", 1, COMPARE_EVENT[0]);
    av(1, 4'h0, 32'h10);
    av(1, 4'h9, {v, 8'h03});
    repeat (4) @(posedge SYS_CLK);
    av(0, 4'h2, 0);
    chk("trigclr", 0, q & 32'hFF);
    av(0, 4'h4, 0);
    chk("trigflag", 0, q & 32'h1);
    av(1, 4'h9, 32'h03);
    repeat (3) @(posedge SYS_CLK);
    chk("convtrig", 1, CONVERSION_TRIGGER[0]);
    av(1, 4'h1, 32'h5A);
    av(0, 4'h1, 0);
    chk("wrwins", 32'h5A, q & 32'hFF);
    setc(16'hFFF0);
    av(1, 4'h9, {16'hFFFF, 8'h03});
    av(1, 4'h0, 32'h11);
    repeat (30) @(posedge SYS_CLK);
    av(1, 4'h0, 32'h10);
    av(0, 4'h4, 0);
    chk("wrapclr", 0, q & 32'h1);
    av(0, 4'h2, 0);
    chk("wraphigh", 0, q & 32'hFF);
    test_done;
  end
endmodule

// ==== testbench/tob_far.sv ====
// Far side: external count clock and capture event source
`timescale 1ns/1ps
module tob_far (
  // Clock
  input wire SYS_CLK,
  // Toward the timer
  output reg EXT_COUNT_CLK,
  output reg [4:0] CAPTURE_EVENT
);
  initial begin
    EXT_COUNT_CLK = 1'b0;
    CAPTURE_EVENT = 5'h0;
  end
  // Slow count clock, still between bursts, also in sleep
  task ext(input integer n);
    repeat (n) begin
      repeat (4) @(posedge SYS_CLK);
      EXT_COUNT_CLK <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      EXT_COUNT_CLK <= 1'b0;
    end
  endtask
  task cap(input integer u);
    begin
      CAPTURE_EVENT[u] <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      CAPTURE_EVENT[u] <= 1'b0;
    end
  endtask
endmodule

// ==== testbench/tob_timer_assertions.sv ====
// Port checker for the overflow timer
`timescale 1ns/1ps
module tob_chk #(
  parameter UNITS = 5
) (
  // Clock, reset and bus
  input wire SYS_CLK,
  input wire SRST,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Status
  input wire SLEEP_ACTIVE,
  input wire IRQ_OUT,
  input wire WAKE_OUT,
  input wire OSC_RUN,
  input wire [UNITS-1:0] COMPARE_EVENT,
  input wire [UNITS-1:0] CONVERSION_TRIGGER
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  wire rq = AVS_READ | AVS_WRITE;
  wire osc_wr = AVS_WRITE && AVS_ADDRESS == 4'h6;
  a_bus_answer: assert property (rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no answer");
  a_bus_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
  a_bus_idle: assert property (!rq |=> AVS_WAITREQUEST) else $error("idle answer");
  a_unmapped_zero: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS > 4'hD |=> AVS_READDATA == 32'h0)
    else $error("unmapped data");
  a_irq_sleep: assert property (SLEEP_ACTIVE |=> !IRQ_OUT) else $error("irq in sleep");
  a_wake_awake: assert property (!SLEEP_ACTIVE |=> !WAKE_OUT) else $error("wake while awake");
  a_trig_match: assert property ((CONVERSION_TRIGGER & ~COMPARE_EVENT) == 0) else $error("trigger no match");
  a_osc_write: assert property ($changed(OSC_RUN) |-> $past(osc_wr) || $past(osc_wr, 2))
    else $error("osc changed");
  cover property (WAKE_OUT);
  cover property (IRQ_OUT);
  cover property (|CONVERSION_TRIGGER);
endmodule
bind tob_timer tob_chk #(.UNITS(UNITS)) u_chk(.SYS_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_READDATA, .AVS_WAITREQUEST, .SLEEP_ACTIVE, .IRQ_OUT, .WAKE_OUT, .OSC_RUN, .COMPARE_EVENT,
  .CONVERSION_TRIGGER);
